// file: include/pbg_pkg.sv
// Shared constants, carriers and decode for the seven-pin general-purpose port.
// Assumes a 32-bit APB master and an on-chip pattern generator as neighbours.
`default_nettype none

package pbg_pkg;

  // Printed register offsets are indices; the byte address is four times the index
  localparam logic [15:0] PBG_DIR_IDX = 16'hffd4;
  localparam logic [15:0] PBG_DATA_IDX = 16'hffd6;
  localparam logic [31:0] PBG_DIR_ADDR = {14'h0, PBG_DIR_IDX, 2'h0};
  localparam logic [31:0] PBG_DATA_ADDR = {14'h0, PBG_DATA_IDX, 2'h0};

  // Values after reset and on reads
  localparam logic [7:0] PBG_DIR_RESET = 8'h00;
  localparam logic [7:0] PBG_DATA_RESET = 8'h00;
  localparam logic [7:0] PBG_DIR_READ = 8'hff;
  localparam logic [31:0] PBG_UNMAPPED_READ = 32'h0;

  // Bit 6 has no pin behind it; it reads as one while it is an input
  localparam logic [7:0] PBG_PIN_MASK = 8'hbf;
  localparam int unsigned PBG_RSV_BIT = 6;
  localparam logic PBG_RSV_LEVEL = 1'h1;

  // APB request as driven by the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pbg_apb_req_t;

  // APB answer of the slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pbg_apb_rsp_t;

  // Pattern generator side: enable bits, next data and a one-cycle transfer pulse
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] next_data;
    logic transfer;
  } pbg_pattern_t;

  // Function that a pin takes
  typedef enum logic [1:0] {
    PBG_INPUT,
    PBG_PORT_OUT,
    PBG_PATTERN_OUT
  } pbg_func_t;

  // Direction and next-data enable select the pin function
  function automatic pbg_func_t pbg_func(input logic dir, input logic nde);
    pbg_func_t f;
    f = PBG_INPUT;
    if (dir) begin
      f = nde ? PBG_PATTERN_OUT : PBG_PORT_OUT;
    end
    return f;
  endfunction

endpackage

`default_nettype wire

// file: design/pbg_apb_slave.sv
// APB slave front end for the port registers: decode, wait state, read answer.
// Assumes the master holds its request until it samples pready high.
`timescale 1ns/1ps
`default_nettype none

module pbg_apb_slave (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Bus
  input wire pbg_pkg::pbg_apb_req_t req_i,
  output pbg_pkg::pbg_apb_rsp_t rsp_o,
  // Register side
  input wire logic [7:0] data_rd_i,
  output logic wr_dir_o,
  output logic wr_data_o
);
  import pbg_pkg::*;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic done;
  logic hit_dir;
  logic hit_data;

  // One wait state: the answer is built a cycle into the access phase
  assign access = req_i.psel & req_i.penable;
  assign done = access & pready_q;
  assign hit_dir = req_i.paddr == PBG_DIR_ADDR;
  assign hit_data = req_i.paddr == PBG_DATA_ADDR;
  assign wr_dir_o = done & req_i.pwrite & hit_dir;
  assign wr_data_o = done & req_i.pwrite & hit_data;

  // Answer flops; reading the direction register gives all ones
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= PBG_UNMAPPED_READ;
    end else begin
      pready_q <= access & ~pready_q;
      if (access & ~pready_q) begin
        pslverr_q <= ~(hit_dir | hit_data);
        if (req_i.pwrite | ~(hit_dir | hit_data)) begin
          prdata_q <= PBG_UNMAPPED_READ;
        end else if (hit_dir) begin
          prdata_q <= {24'h0, PBG_DIR_READ};
        end else begin
          prdata_q <= {24'h0, data_rd_i};
        end
      end
    end
  end

  assign rsp_o = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

endmodule

`default_nettype wire

// file: design/pbg_pin_cell.sv
// One port pin: function decode and registered output driver and enable.
// Assumes the pad ring combines output and enable into the real pin.
`timescale 1ns/1ps
`default_nettype none

module pbg_pin_cell #(
  parameter logic PRESENT = 1'h1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Control
  input wire logic dir_i,
  input wire logic nde_i,
  input wire logic data_i,
  input wire logic hold_i,
  // Pad side
  output logic out_o,
  output logic oe_o,
  output logic pattern_o
);
  import pbg_pkg::*;

  pbg_func_t func;

  assign func = pbg_func(dir_i, nde_i);

  // Drivers follow the registers one edge later; software standby (hold_i) freezes them
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      out_o <= 1'h0;
      oe_o <= 1'h0;
      pattern_o <= 1'h0;
    end else if (!hold_i) begin
      out_o <= PRESENT & data_i;
      oe_o <= PRESENT & (func != PBG_INPUT);
      pattern_o <= PRESENT & (func == PBG_PATTERN_OUT);
    end
  end

endmodule

`default_nettype wire

// file: design/pbg_port.sv
// Seven-pin general-purpose port with direction and data registers on APB.
// Assumes synchronous pin inputs and a pattern generator on the same clock.
//
// How it works
// - Seven pins at bits 7 and 5..0; bit 6 has no pin.
// - Pin functions are the same in every chip operating mode.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only; reads return all ones.
// - Direction clears on reset and hardware standby, holds in software standby.
// - In software standby, output pins keep driving their level.
// - Data reads give the latch for outputs and pin level for inputs.
// - Data bit 6 stores writes and reads back, never touches a pin.
// - Bit 6 reads stored value when its direction is 1, else one.
// - Data clears on reset and hardware standby, holds in software standby.
// - Data register holds pattern output values for groups 2 and 3.
// - Enabled next-data bits ignore CPU writes; only transfers and hardware standby change them.
// - Direction 0 input, 1 with enable 0 port out, else pattern out.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module pbg_port (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // APB register bus
  input wire pbg_pkg::pbg_apb_req_t apb_req_i,
  output pbg_pkg::pbg_apb_rsp_t apb_rsp_o,
  // Power state
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  // Pattern generator
  input wire pbg_pkg::pbg_pattern_t pattern_i,
  output logic [7:0] pattern_active_o,
  // Pins
  input wire logic [7:0] pin_in_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o
);
  import pbg_pkg::*;

  logic [7:0] port_b_direction_q;
  logic [7:0] port_b_direction_d;
  logic [7:0] port_b_data_q;
  logic [7:0] port_b_data_d;
  logic [7:0] next_data_enable_b;
  logic [7:0] pin_level;
  logic [7:0] data_rd;
  logic wr_dir;
  logic wr_data;
  logic [7:0] wdata;

  assign next_data_enable_b = pattern_i.enable;
  assign wdata = apb_req_i.pwdata[7:0];

  // Bus front end; its answer flops drive the bus outputs directly
  pbg_apb_slave u_apb (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .req_i(apb_req_i),
    .rsp_o(apb_rsp_o),
    .data_rd_i(data_rd),
    .wr_dir_o(wr_dir),
    .wr_data_o(wr_data)
  );

  // Pin level with the missing bit 6 pad reading as one
  always_comb begin
    pin_level = pin_in_i;
    pin_level[PBG_RSV_BIT] = PBG_RSV_LEVEL;
  end

  // Latch for outputs, pad for inputs; bit 6 falls out of the same mux
  assign data_rd = (port_b_direction_q & port_b_data_q) | (~port_b_direction_q & pin_level);

  // Direction register next value
  always_comb begin
    port_b_direction_d = port_b_direction_q;
    if (hw_standby_i) begin
      port_b_direction_d = PBG_DIR_RESET;
    end else if (wr_dir) begin
      port_b_direction_d = wdata;
    end
  end

  // Direction register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      port_b_direction_q <= PBG_DIR_RESET;
    end else begin
      port_b_direction_q <= port_b_direction_d;
    end
  end

  // Data register next value: locked bits follow only the pattern generator and hardware standby
  always_comb begin
    port_b_data_d = port_b_data_q;
    if (wr_data) begin
      port_b_data_d = (wdata & ~next_data_enable_b) | (port_b_data_q & next_data_enable_b);
    end
    if (pattern_i.transfer) begin
      port_b_data_d = (port_b_data_d & ~next_data_enable_b)
                      | (pattern_i.next_data & next_data_enable_b);
    end
    if (hw_standby_i) begin
      port_b_data_d = PBG_DATA_RESET;
    end
  end

  // Data register; software standby simply leaves it untouched
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      port_b_data_q <= PBG_DATA_RESET;
    end else begin
      port_b_data_q <= port_b_data_d;
    end
  end

  // One cell per bit; no mode input exists, so every mode sees the same pins
  for (genvar i = 0; i < 8; i++) begin : g_pin
    pbg_pin_cell #(
      .PRESENT(PBG_PIN_MASK[i])
    ) u_cell (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .dir_i(port_b_direction_q[i]),
      .nde_i(next_data_enable_b[i]),
      .data_i(port_b_data_q[i]),
      .hold_i(sw_standby_i),
      .out_o(pin_out_o[i]),
      .oe_o(pin_oe_o[i]),
      .pattern_o(pattern_active_o[i])
    );
  end

  // Checks on the port's own behaviour

  // Bit 6 never drives a pad
  rsv_pin_quiet_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !pin_oe_o[PBG_RSV_BIT] && !pin_out_o[PBG_RSV_BIT] && !pattern_active_o[PBG_RSV_BIT]
  ) else $error("reserved bit 6 reached a pin");

  // Enables track the direction register one edge after it
  oe_follows_dir_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !sw_standby_i |=> pin_oe_o == ($past(port_b_direction_q) & PBG_PIN_MASK)
  ) else $error("pin enable does not follow direction");

  // A data write shows on the pads two edges after it is taken
  write_to_pin_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (wr_data && !hw_standby_i && !pattern_i.transfer && next_data_enable_b == 8'h00)
    ##1 !sw_standby_i
    |=> pin_out_o == ($past(wdata, 2) & PBG_PIN_MASK)
  ) else $error("written data did not reach the pin drivers");

  // A completed direction read returns all ones
  dir_read_ones_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready
    && !apb_req_i.pwrite && apb_req_i.paddr == PBG_DIR_ADDR
    |-> apb_rsp_o.prdata == {24'h0, PBG_DIR_READ}
  ) else $error("direction register read back its contents");

  // A completed data read returns the mux value built one cycle earlier
  data_read_mux_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready
    && !apb_req_i.pwrite && apb_req_i.paddr == PBG_DATA_ADDR
    |-> apb_rsp_o.prdata == {24'h0, $past(data_rd)}
  ) else $error("data read returned the wrong source");

  // Bit 6 reads as one while its direction bit is clear
  rsv_read_one_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !port_b_direction_q[PBG_RSV_BIT] |-> data_rd[PBG_RSV_BIT] == PBG_RSV_LEVEL
  ) else $error("bit 6 input did not read as one");

  // Hardware standby clears both registers at the next edge
  hw_standby_clear_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    hw_standby_i |=> port_b_direction_q == PBG_DIR_RESET && port_b_data_q == PBG_DATA_RESET
  ) else $error("hardware standby did not clear the registers");

  // Software standby keeps drivers and levels frozen
  sw_standby_hold_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    sw_standby_i ##1 sw_standby_i |-> $stable(pin_out_o) && $stable(pin_oe_o)
  ) else $error("pins moved during software standby");

  // Registers hold when no write, transfer or hardware standby occurs
  reg_hold_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !wr_dir && !wr_data && !pattern_i.transfer && !hw_standby_i
    |=> $stable(port_b_direction_q) && $stable(port_b_data_q)
  ) else $error("register changed without a cause");

  // Locked bits ignore CPU writes
  locked_bits_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    wr_data && !pattern_i.transfer && !hw_standby_i
    |=> ((port_b_data_q ^ $past(port_b_data_q)) & $past(next_data_enable_b)) == 8'h00
  ) else $error("CPU write changed a locked data bit");

  // A transfer loads the next data into the enabled bits
  transfer_load_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    pattern_i.transfer && !hw_standby_i
    |=> (port_b_data_q & $past(next_data_enable_b))
        == ($past(pattern_i.next_data) & $past(next_data_enable_b))
  ) else $error("pattern transfer did not load enabled bits");

  // Bit 6 stores what software writes when unlocked
  rsv_store_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    wr_data && !next_data_enable_b[PBG_RSV_BIT] && !hw_standby_i
    |=> port_b_data_q[PBG_RSV_BIT] == $past(wdata[PBG_RSV_BIT])
  ) else $error("bit 6 did not store the written value");

  // Pattern function needs both direction and enable set
  pattern_func_a: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !sw_standby_i
    |=> pattern_active_o == ($past(port_b_direction_q & next_data_enable_b) & PBG_PIN_MASK)
  ) else $error("pattern function selection wrong");

endmodule

`default_nettype wire

// file: test/pbg_far_model.sv
// Far-side model of the port: the pads on the board and a pattern generator stub.
// Assumes the testbench sets the outside levels and commands each transfer.
`timescale 1ns/1ps
`default_nettype none

module pbg_far_model (
  // Design side
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  output logic [7:0] pin_in_o,
  output pbg_pkg::pbg_pattern_t pattern_o,
  // Testbench commands
  input wire logic [7:0] ext_i,
  input wire logic [7:0] nde_i,
  input wire logic [7:0] next_i,
  input wire logic fire_i
);
  import pbg_pkg::*;

  // Wire level: the port wins where it drives, the outside source elsewhere
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);

  // Generator: fire_i is held for one cycle only, so transfer is a pulse
  assign pattern_o = '{enable: nde_i, next_data: next_i, transfer: fire_i};
endmodule

`default_nettype wire

// file: test/test_pbg_port.sv
// Self-checking testbench for the seven-pin port: APB tasks and directed sequences.
// Assumes the far-side model resolves the pins and drives the pattern inputs.
`timescale 1ns/1ps
`default_nettype none

module test_pbg_port;
  import pbg_pkg::*;

  logic clock_i;
  logic reset_i;
  logic hw_sb;
  logic sw_sb;
  logic fire;
  logic [7:0] ext;
  logic [7:0] nde;
  logic [7:0] nxt;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pat_act;
  pbg_apb_req_t req;
  pbg_apb_rsp_t rsp;
  pbg_pattern_t pat;
  int err_count;
  int n_checks;

  pbg_port i_dut (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .apb_req_i(req),
    .apb_rsp_o(rsp),
    .hw_standby_i(hw_sb),
    .sw_standby_i(sw_sb),
    .pattern_i(pat),
    .pattern_active_o(pat_act),
    .pin_in_i(pin_in),
    .pin_out_o(pin_out),
    .pin_oe_o(pin_oe)
  );

  pbg_far_model i_far (
    .pin_out_i(pin_out),
    .pin_oe_i(pin_oe),
    .pin_in_o(pin_in),
    .pattern_o(pat),
    .ext_i(ext),
    .nde_i(nde),
    .next_i(nxt),
    .fire_i(fire)
  );

  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at a rising edge,
  // where the answer is taken and the request dropped in the same step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [32:0] r);
    int n;
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clock_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
    end
    r = {rsp.pslverr, rsp.prdata};
    req <= '0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [32:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] x);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, {25'h0, x});
  endtask

  // Pins follow a write one edge after it lands, so give them two edges
  task automatic pins(input logic [7:0] o, input logic [7:0] oe);
    repeat (2) @(posedge clock_i);
    #1;
    chk({17'h0, pin_out, pin_oe}, {17'h0, o, oe});
  endtask

  // Expected data read: latch where output, pin where input, bit 6 one as input
  function automatic logic [7:0] exp_rd(input logic [7:0] d, input logic [7:0] l, input logic [7:0] e);
    exp_rd = (l & d) | (e & ~d);
    if (!d[6]) begin
      exp_rd[6] = 1'b1;
    end
  endfunction

  // Directed sequence
  initial begin
    logic [32:0] r;
    reset_i = 1'b1;
    req = '0;
    hw_sb = 1'b0;
    sw_sb = 1'b0;
    fire = 1'b0;
    ext = 8'h33;
    nde = 8'h00;
    nxt = 8'h00;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(PBG_DIR_ADDR, 8'hff);
    rd(PBG_DATA_ADDR, exp_rd(8'h00, 8'h00, 8'h33));
    wr(PBG_DIR_ADDR, 8'hf0);
    wr(PBG_DATA_ADDR, 8'h5a);
    // Drive level is the latch on every present pin; the enable decides what leaves
    pins(8'h1a, 8'hb0);
    rd(PBG_DATA_ADDR, exp_rd(8'hf0, 8'h5a, 8'h33));
    rd(PBG_DIR_ADDR, 8'hff);
    wr(PBG_DIR_ADDR, 8'h0f);
    rd(PBG_DATA_ADDR, exp_rd(8'h0f, 8'h5a, 8'h33));
    // Unmapped place answers with an error and zero data
    apb(1'b0, 32'h0000_0100, 32'h0, r);
    chk(r, {1'b1, 32'h0});
    // Pattern lock on the low nibble
    wr(PBG_DIR_ADDR, 8'hff);
    wr(PBG_DATA_ADDR, 8'h0f);
    @(posedge clock_i);
    nde <= 8'h0f;
    wr(PBG_DATA_ADDR, 8'ha5);
    rd(PBG_DATA_ADDR, 8'haf);
    #1;
    chk({25'h0, pat_act}, {25'h0, 8'h0f});
    @(posedge clock_i);
    nxt <= 8'h06;
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    rd(PBG_DATA_ADDR, 8'ha6);
    pins(8'ha6, 8'hbf);
    // Software standby freezes the pins while the register still takes writes
    @(posedge clock_i);
    sw_sb <= 1'b1;
    wr(PBG_DATA_ADDR, 8'h5a);
    pins(8'ha6, 8'hbf);
    rd(PBG_DATA_ADDR, 8'h56);
    @(posedge clock_i);
    sw_sb <= 1'b0;
    pins(8'h16, 8'hbf);
    // Hardware standby clears both registers
    @(posedge clock_i);
    hw_sb <= 1'b1;
    nde <= 8'h00;
    repeat (2) @(posedge clock_i);
    hw_sb <= 1'b0;
    pins(8'h00, 8'h00);
    rd(PBG_DATA_ADDR, exp_rd(8'h00, 8'h00, 8'h33));
    summarize();
  end

  // Watchdog: the sequence needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
